// File: asrc_top.sv
// asrc_top: auto sleep/wake rate control with its control registers.
// assumes an AXI4-Lite master and one-cycle event pulses from the detectors.
`timescale 1ns/10ps
module asrc_top
    import asrc_pkg::*;
#(
    parameter int BASE_TICK_CYCLES = BASE_TICK_CYCLES_DFLT
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input asrc_events_t det_events,
    output logic active_mode,
    output logic sleep_mode,
    output logic sample_tick,
    output logic [2:0] sample_rate_code,
    output logic low_noise_select,
    output logic fast_read_select,
    output logic sleep_wake_irq
);
    logic [7:0] inactivity_duration_r;
    logic [7:0] system_control_one_r;
    logic [7:0] system_control_two_r;
    logic [7:0] wake_source_control_r;
    logic [7:0] interrupt_enable_control_r;
    logic flag_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire_r;
    asrc_state_t state_r;
    asrc_state_t state_nxt;
    logic base_tick;
    logic expired;
    logic restart;
    logic wake_hit;
    logic [3:0] fn_events;
    logic [3:0] fn_wake_mask;
    logic flag_set;
    logic flag_clr;
    logic [1:0] mode_code;
    logic [31:0] rd_word;

    function automatic logic mapped(input logic [7:0] a);
        if (a == reg_addr(IDX_INACT))
            return 1'b1;
        else if (a == reg_addr(IDX_SC1))
            return 1'b1;
        else if (a == reg_addr(IDX_SC2))
            return 1'b1;
        else if (a == reg_addr(IDX_WAKE))
            return 1'b1;
        else if (a == reg_addr(IDX_IEN))
            return 1'b1;
        else if (a == reg_addr(IDX_STAT))
            return 1'b1;
        else
            return 1'b0;
    endfunction

    function automatic logic wr_hit(input logic [7:0] idx, input logic fire, input logic [7:0] a,
                                    input logic [3:0] strb);
        return fire && (a == reg_addr(idx)) && strb[0];
    endfunction

    // write address channel; taken once, released after the response
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_r <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready)
            s_axi_awready <= 1'b1;
    end

    // write data channel, independent of the address so either may come first
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready)
            s_axi_wready <= 1'b1;
    end

    // one write pulse once both halves are held, then the response
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            wr_fire_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            wr_fire_r <= !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !wr_fire_r;
            if (wr_fire_r) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read mux; registers are bytes in the low lane, upper bits read zero
    always_comb
    begin
        rd_word = 32'h00000000;
        if (s_axi_araddr == reg_addr(IDX_INACT))
            rd_word[7:0] = inactivity_duration_r;
        else if (s_axi_araddr == reg_addr(IDX_SC1))
            rd_word[7:0] = system_control_one_r;
        else if (s_axi_araddr == reg_addr(IDX_SC2))
            rd_word[7:0] = system_control_two_r;
        else if (s_axi_araddr == reg_addr(IDX_WAKE))
            rd_word[7:0] = wake_source_control_r;
        else if (s_axi_araddr == reg_addr(IDX_IEN))
            rd_word[7:0] = interrupt_enable_control_r;
        else if (s_axi_araddr == reg_addr(IDX_STAT))
            rd_word[7:0] = {flag_r, 5'b00000, mode_code};
    end

    // read channel; data answers one edge after the address is taken
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // inactivity duration, plain byte
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            inactivity_duration_r <= REG_RST;
        else if (wr_hit(IDX_INACT, wr_fire_r, awaddr_r, wstrb_r))
            inactivity_duration_r <= wdata_r[7:0];
    end

    // control one: while active only the active bit follows a write
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            system_control_one_r <= REG_RST;
        else if (wr_hit(IDX_SC1, wr_fire_r, awaddr_r, wstrb_r)) begin
            if (system_control_one_r[SC1_ACTIVE_BIT])
                system_control_one_r[SC1_ACTIVE_BIT] <= wdata_r[SC1_ACTIVE_BIT];
            else
                system_control_one_r <= wdata_r[7:0];
        end
    end

    // control two, wake selects, interrupt enables
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            system_control_two_r <= REG_RST;
            wake_source_control_r <= REG_RST;
            interrupt_enable_control_r <= REG_RST;
        end else begin
            if (wr_hit(IDX_SC2, wr_fire_r, awaddr_r, wstrb_r))
                system_control_two_r <= wdata_r[7:0] & SC2_MASK;
            if (wr_hit(IDX_WAKE, wr_fire_r, awaddr_r, wstrb_r))
                wake_source_control_r <= wdata_r[7:0] & WAKE_MASK;
            if (wr_hit(IDX_IEN, wr_fire_r, awaddr_r, wstrb_r))
                interrupt_enable_control_r <= wdata_r[7:0] & IEN_MASK;
        end
    end

    // detector events; sample-ready and sleep/wake are left out on purpose
    assign fn_events = {det_events.transient_event, det_events.orientation_event,
                        det_events.tap_event, det_events.freefall_motion_event};
    assign restart = |fn_events;
    assign fn_wake_mask = wake_source_control_r[FN_LSB +: 4]
                          & interrupt_enable_control_r[IEN_FN_LSB +: 4];
    assign wake_hit = |(fn_events & fn_wake_mask);

    // mode sequencing
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_STANDBY:
            begin
                if (system_control_one_r[SC1_ACTIVE_BIT])
                    state_nxt = ST_WAKE;
            end
            ST_WAKE:
            begin
                if (!system_control_one_r[SC1_ACTIVE_BIT])
                    state_nxt = ST_STANDBY;
                else if (system_control_two_r[SC2_SLEEP_EN_BIT] && expired && !restart)
                    state_nxt = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (!system_control_one_r[SC1_ACTIVE_BIT])
                    state_nxt = ST_STANDBY;
                else if (!system_control_two_r[SC2_SLEEP_EN_BIT])
                    state_nxt = ST_WAKE;
                else if (wake_hit)
                    state_nxt = ST_WAKE;
            end
            default: state_nxt = ST_STANDBY;
        endcase
    end

    // state and the mode outputs, all registered together
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            state_r <= ST_STANDBY;
            active_mode <= 1'b0;
            sleep_mode <= 1'b0;
            sample_rate_code <= 3'h0;
        end else begin
            state_r <= state_nxt;
            active_mode <= (state_nxt != ST_STANDBY);
            sleep_mode <= (state_nxt == ST_SLEEP);
            if (state_nxt == ST_SLEEP)
                sample_rate_code <= sleep_rate_code(system_control_one_r[SC1_ASLP_LSB +: 2]);
            else
                sample_rate_code <= system_control_one_r[SC1_RATE_LSB +: 3];
        end
    end

    assign mode_code = (state_r == ST_SLEEP) ? MODE_SLEEP :
                       (state_r == ST_WAKE) ? MODE_WAKE : MODE_STANDBY;

    // sleep/wake flag: set wins over a write-one clear in the same cycle
    assign flag_set = interrupt_enable_control_r[IEN_ASLP_BIT]
                      && (((state_r == ST_WAKE) && (state_nxt == ST_SLEEP))
                      || ((state_r == ST_SLEEP) && (state_nxt == ST_WAKE)));
    assign flag_clr = wr_hit(IDX_STAT, wr_fire_r, awaddr_r, wstrb_r) && wdata_r[STAT_FLAG_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            flag_r <= 1'b0;
            sleep_wake_irq <= 1'b0;
        end else begin
            flag_r <= flag_set || (flag_r && !flag_clr);
            sleep_wake_irq <= flag_set || (flag_r && !flag_clr);
        end
    end

    // option bits handed to the data path
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n) begin
            low_noise_select <= 1'b0;
            fast_read_select <= 1'b0;
        end else begin
            low_noise_select <= system_control_one_r[SC1_NOISE_BIT];
            fast_read_select <= system_control_one_r[SC1_FREAD_BIT];
        end
    end

    asrc_timebase #(
        .BASE_CYCLES(BASE_TICK_CYCLES)
    ) u_timebase (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(active_mode),
        .rate_code(sample_rate_code),
        .base_tick(base_tick),
        .sample_tick(sample_tick)
    );

    // timer only runs awake; sleep clears it, so a wake restarts it from zero
    asrc_inact_timer u_inact (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(state_r == ST_WAKE),
        .restart(restart),
        .base_tick(base_tick),
        .long_step(system_control_one_r[SC1_RATE_LSB +: 3] == RATE_1P56),
        .duration(inactivity_duration_r),
        .expired(expired)
    );
endmodule // asrc_top

// File: asrc_pkg.sv
// asrc_pkg: constants, types and helpers for the auto-sleep rate control block.
// assumes a 100 MHz sys_clk and 32-bit AXI4-Lite register access.
package asrc_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int BASE_PERIOD_US = 1250;  // 1.25 ms, the 800 Hz period
    localparam int STEP_SHORT_MS = 320;
    localparam int STEP_LONG_MS = 640;
    localparam int BASE_TICK_CYCLES_DFLT = BASE_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam logic [9:0] STEP_SHORT_TICKS = 10'(STEP_SHORT_MS * 1000 / BASE_PERIOD_US);
    localparam logic [9:0] STEP_LONG_TICKS = 10'(STEP_LONG_MS * 1000 / BASE_PERIOD_US);

    // sample period in 1.25 ms base ticks per output rate code
    localparam logic [9:0] TICKS_800 = 10'h001;
    localparam logic [9:0] TICKS_400 = 10'h002;
    localparam logic [9:0] TICKS_200 = 10'h004;
    localparam logic [9:0] TICKS_100 = 10'h008;
    localparam logic [9:0] TICKS_50 = 10'h010;
    localparam logic [9:0] TICKS_12P5 = 10'h040;
    localparam logic [9:0] TICKS_6P25 = 10'h080;
    localparam logic [9:0] TICKS_1P56 = 10'h200;
    localparam logic [2:0] RATE_1P56 = 3'h7;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_INACT = 8'h29;
    localparam logic [7:0] IDX_SC1 = 8'h2A;
    localparam logic [7:0] IDX_SC2 = 8'h2B;
    localparam logic [7:0] IDX_WAKE = 8'h2C;
    localparam logic [7:0] IDX_IEN = 8'h2D;
    localparam logic [7:0] IDX_STAT = 8'h30;

    localparam logic [7:0] REG_RST = 8'h00;
    localparam int SC1_ACTIVE_BIT = 0;
    localparam int SC1_FREAD_BIT = 1;
    localparam int SC1_NOISE_BIT = 2;
    localparam int SC1_RATE_LSB = 3;
    localparam int SC1_ASLP_LSB = 6;
    localparam int SC2_SLEEP_EN_BIT = 2;
    localparam logic [7:0] SC2_MASK = 8'h9F;  // software reset bit reads zero
    localparam logic [7:0] WAKE_MASK = 8'h7B;
    localparam logic [7:0] IEN_MASK = 8'hBD;
    localparam int FN_LSB = 3;  // wake selects ffmt,tap,orient,trans at bits 3..6
    localparam int IEN_FN_LSB = 2;  // enables ffmt,tap,orient,trans at bits 2..5
    localparam int IEN_ASLP_BIT = 7;
    localparam int STAT_FLAG_BIT = 7;

    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_WAKE = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_WAKE = 3'b010,
        ST_SLEEP = 3'b100
    } asrc_state_t;

    // detector event pulses, one cycle each
    typedef struct packed {
        logic transient_event;
        logic orientation_event;
        logic tap_event;
        logic freefall_motion_event;
        logic sample_ready_event;
    } asrc_events_t;

    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    function automatic logic [9:0] rate_ticks(input logic [2:0] code);
        case (code)
            3'h0: return TICKS_800;
            3'h1: return TICKS_400;
            3'h2: return TICKS_200;
            3'h3: return TICKS_100;
            3'h4: return TICKS_50;
            3'h5: return TICKS_12P5;
            3'h6: return TICKS_6P25;
            default: return TICKS_1P56;
        endcase
    endfunction

    // sleep code 00..11 maps onto output codes 100..111
    function automatic logic [2:0] sleep_rate_code(input logic [1:0] s);
        return {1'b1, s};
    endfunction

endpackage

// File: asrc_timebase.sv
// asrc_timebase: 1.25 ms base tick and sample tick at the selected rate.
// assumes rate_code only changes from a registered source.
`timescale 1ns/10ps
module asrc_timebase
    import asrc_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_TICK_CYCLES_DFLT
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] rate_code,
    output logic base_tick,
    output logic sample_tick
);
    localparam int PW = $clog2(BASE_CYCLES + 1);
    logic [PW-1:0] pre_cnt_r;
    logic [9:0] div_cnt_r;
    logic [2:0] rate_d_r;
    logic pre_wrap;

    assign pre_wrap = (pre_cnt_r == PW'(BASE_CYCLES - 1));

    // base prescaler, held at zero in standby
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !run) begin
            pre_cnt_r <= '0;
            base_tick <= 1'b0;
        end else begin
            pre_cnt_r <= pre_wrap ? '0 : pre_cnt_r + 1'b1;
            base_tick <= pre_wrap;
        end
    end

    // sample divider restarts on any rate change so the new period starts clean
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !run) begin
            div_cnt_r <= '0;
            rate_d_r <= 3'h0;
            sample_tick <= 1'b0;
        end else begin
            rate_d_r <= rate_code;
            sample_tick <= 1'b0;
            if (rate_d_r != rate_code)
                div_cnt_r <= '0;
            else if (pre_wrap) begin
                if (div_cnt_r == rate_ticks(rate_code) - 10'h001) begin
                    div_cnt_r <= '0;
                    sample_tick <= 1'b1;
                end else
                    div_cnt_r <= div_cnt_r + 10'h001;
            end
        end
    end
endmodule // asrc_timebase

// File: asrc_inact_timer.sv
// asrc_inact_timer: counts inactivity in 320 ms or 640 ms units.
// assumes base_tick is a one-cycle pulse every 1.25 ms while active.
`timescale 1ns/10ps
module asrc_inact_timer
    import asrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    input wire logic base_tick,
    input wire logic long_step,
    input wire logic [7:0] duration,
    output logic expired
);
    logic [9:0] step_cnt_r;
    logic [7:0] units_r;
    logic [9:0] step_len;

    assign step_len = long_step ? STEP_LONG_TICKS : STEP_SHORT_TICKS;

    // units saturate at 255 so a long quiet spell never wraps back to zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !run || restart) begin
            step_cnt_r <= '0;
            units_r <= 8'h00;
        end else if (base_tick) begin
            if (step_cnt_r >= step_len - 10'h001) begin
                step_cnt_r <= '0;
                if (units_r != 8'hFF)
                    units_r <= units_r + 8'h01;
            end else
                step_cnt_r <= step_cnt_r + 10'h001;
        end
    end

    // expiry level, cleared the cycle after a restart
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !run || restart)
            expired <= 1'b0;
        else
            expired <= (units_r >= duration);
    end
endmodule // asrc_inact_timer

// File: asrc_monitor.sv
// asrc_monitor: bus and mode checks on the ports of asrc_top.
// assumes it is bound into asrc_top and sees only its ports.
`timescale 1ns/10ps
module asrc_monitor
    import asrc_pkg::*;
#(
    parameter int BASE_TICK_CYCLES = 4
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input asrc_events_t det_events,
    input wire logic active_mode,
    input wire logic sleep_mode,
    input wire logic sample_tick,
    input wire logic [2:0] sample_rate_code,
    input wire logic low_noise_select,
    input wire logic fast_read_select,
    input wire logic sleep_wake_irq
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // address and data taken on one edge
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // response exactly three edges later, never sooner
    sequence wr_resp;
        !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    wr_answer_a: assert property (wr_take |=> wr_resp)
        else $error("write response timing wrong");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    sleep_nest_a: assert property (sleep_mode |-> active_mode)
        else $error("sleep outside active");
    // second cycle of sleep, though the rate code is registered on the same edge as sleep_mode
    sleep_rate_a: assert property (sleep_mode ##1 sleep_mode |-> sample_rate_code[2])
        else $error("sleep rate not applied");
    ready_no_wake_a: assert property (sleep_mode && det_events == 5'h01 |=> sleep_mode || s_axi_bvalid)
        else $error("sample ready woke device");
    tick_pulse_a: assert property (sample_tick |=> !sample_tick [*3])
        else $error("sample tick too long");
    ctrl_lock_a: assert property (!$stable({low_noise_select, fast_read_select}) |-> !$past(active_mode))
        else $error("control changed while active");
    irq_cause_a: assert property ($rose(sleep_wake_irq) |-> $changed(sleep_mode))
        else $error("interrupt without transition");
endmodule // asrc_monitor
bind asrc_top asrc_monitor #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) mon (.sys_clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .det_events, .active_mode, .sleep_mode, .sample_tick, .sample_rate_code, .low_noise_select,
    .fast_read_select, .sleep_wake_irq);

// File: asrc_host_model.sv
// asrc_host_model: register host on the far side of the AXI4-Lite port.
// assumes one call at a time; waits have no limit, the bench timeout ends a hang.
`timescale 1ns/10ps
module asrc_host_model
    import asrc_pkg::*;
(
    input wire logic sys_clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle bus from time zero
    initial
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    // one transfer; each channel dropped only at the edge that takes it
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q,
        output logic [1:0] r);
        @(posedge sys_clk);
        {awaddr, araddr} <= {2{idx[5:0], 2'b00}};
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= {3{we}};
        {arvalid, rready} <= {2{!we}};
        do
        begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end
        while (!(bvalid || rvalid));
        q = rdata[7:0];
        r = we ? bresp : rresp;
        {bready, rready} <= 2'b00;
    endtask
endmodule // asrc_host_model

// File: tb.sv
// tb: self-checking bench for asrc_top driven through the host model.
// assumes BASE_TICK_CYCLES of 4, so one 320 ms unit lasts 1024 cycles.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb
    import asrc_pkg::*;
;
    localparam int BT = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    asrc_events_t ev = '0;
    logic [7:0] awaddr, araddr, rd, v;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, rs;
    logic sleep_mode, low_noise_select, fast_read_select, sleep_wake_irq, sample_tick;
    logic [2:0] sample_rate_code, rt;
    int slp_ms[4] = '{20, 80, 160, 640};  // sleep rate periods
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int c;
    asrc_top #(.BASE_TICK_CYCLES(BT)) dut (.sys_clk, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .det_events(ev), .active_mode(),
        .sleep_mode, .sample_tick, .sample_rate_code, .low_noise_select, .fast_read_select, .sleep_wake_irq);
    asrc_host_model host (.sys_clk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // hang guard, well above the roughly 10000 cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    // 256 base ticks per unit, 512 at the slowest rate
    function automatic int unit_cycles(input logic [2:0] r);
        return (r == RATE_1P56 ? 512 : 256) * BT;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic pulse(input asrc_events_t e);
        @(posedge sys_clk);
        ev <= e;
        @(posedge sys_clk);
        ev <= '0;
        #1;
    endtask
    // standby first, so every field of the new setting is accepted
    task automatic go(input logic [7:0] s);
        host.xfer(1'b1, IDX_SC1, 8'h00, rd, rs);
        host.xfer(1'b1, IDX_SC1, s, rd, rs);
    endtask
    task automatic doze(output int n);
        n = 0;
        while (!sleep_mode && n < 5000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    // tick to tick spacing
    task automatic gap(output int n);
        @(posedge sample_tick);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (!sample_tick);
    endtask
    initial
    begin
        void'($urandom(32'h25C50BE0));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            host.xfer(1'b0, IDX_INACT + 8'(i), 8'h00, rd, rs);
            `CHK("reset value", 8'h00, rd)
        end
        v = 8'($urandom);
        host.xfer(1'b1, IDX_INACT, v, rd, rs);
        `CHK("write resp", RESP_OKAY, rs)
        host.xfer(1'b0, IDX_INACT, 8'h00, rd, rs);
        `CHK("duration", v, rd)
        host.xfer(1'b0, 8'h2E, 8'h00, rd, rs);
        `CHK("unmapped", RESP_SLVERR, rs)
        $display("test registers done");
        // auto-sleep off: stays awake at the chosen rate
        host.xfer(1'b1, IDX_INACT, 8'h00, rd, rs);
        host.xfer(1'b1, IDX_IEN, 8'hBD, rd, rs);
        v = 8'($urandom) | 8'h01;
        go(v);
        repeat (40) @(posedge sys_clk);
        #1;
        `CHK("no sleep", 1'b0, sleep_mode)
        `CHK("rate", v[5:3], sample_rate_code)
        `CHK("low noise", v[2], low_noise_select)
        `CHK("fast read", v[1], fast_read_select)
        $display("test no sleep done");
        host.xfer(1'b1, IDX_SC2, 8'h04, rd, rs);
        for (int s = 0; s < 4; s++)
        begin
            rt = 3'($urandom);
            go({2'(s), rt, 3'h1});
            doze(c);
            `CHK("asleep", 1'b1, sleep_mode)
            `CHK("sleep rate", {1'b1, 2'(s)}, sample_rate_code)
            gap(c);
            `CHK("sleep period", slp_ms[s] * 1000 / BASE_PERIOD_US * BT, c)
            `CHK("irq", 1'b1, sleep_wake_irq)
            host.xfer(1'b0, IDX_STAT, 8'h00, rd, rs);
            `CHK("status", 8'h82, rd)
            host.xfer(1'b1, IDX_STAT, 8'h80, rd, rs);
            `CHK("irq clear", 1'b0, sleep_wake_irq)
        end
        $display("test sleep rates done");
        // each source: bypassed, then not enabled, then qualifying
        for (int f = 0; f < 4; f++)
        begin
            host.xfer(1'b1, IDX_WAKE, 8'h00, rd, rs);
            pulse(asrc_events_t'(5'h01));
            `CHK("ready", 1'b1, sleep_mode)
            pulse(asrc_events_t'(5'(2 << f)));
            `CHK("bypassed", 1'b1, sleep_mode)
            host.xfer(1'b1, IDX_WAKE, 8'(8 << f), rd, rs);
            host.xfer(1'b1, IDX_IEN, 8'hBD ^ 8'(4 << f), rd, rs);
            pulse(asrc_events_t'(5'(2 << f)));
            `CHK("not enabled", 1'b1, sleep_mode)
            host.xfer(1'b1, IDX_IEN, 8'hBD, rd, rs);
            pulse(asrc_events_t'(5'(2 << f)));
            `CHK("woken", 1'b0, sleep_mode)
            `CHK("wake rate", rt, sample_rate_code)
            doze(c);
        end
        $display("test wake sources done");
        // a mid-way transient event restarts the count
        host.xfer(1'b1, IDX_INACT, 8'h01, rd, rs);
        for (int k = 0; k < 2; k++)
        begin
            rt = k ? RATE_1P56 : 3'($urandom % 7);
            go({2'h0, rt, 3'h1});
            repeat (300) @(posedge sys_clk);
            pulse(asrc_events_t'(5'h10));
            doze(c);
            `CHK("unit", 1'b1, c > unit_cycles(rt) - 12 && c < unit_cycles(rt) + 12)
        end
        $display("test duration done");
        end_of_test();
    end
endmodule // tb
